// File: hdl/lighting_regs_pkg.sv
// Package with register map, field layout and controller states for the boost and PWM registers
package lighting_regs_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [7:0] BOOST_LEVEL_OFFSET   = 8'h0D;
  localparam logic [7:0] EXT_DIM_SAFE_OFFSET  = 8'h2B;
  localparam logic [7:0] BOOST_LEVEL_RESET    = 8'h08;
  localparam logic [7:0] EXT_DIM_SAFE_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ        = 8'h00;

  // ----------------------------------------------------------------------
  // Boost code range, one volt per step
  // ----------------------------------------------------------------------
  localparam logic [7:0] BOOST_CODE_MIN       = 8'h08;
  localparam logic [7:0] BOOST_CODE_MAX       = 8'h14;

  // ----------------------------------------------------------------------
  // Field positions of the external control register
  // ----------------------------------------------------------------------
  localparam int SAFE_RED_BIT                 = 7;
  localparam int SAFE_GREEN_BIT               = 6;
  localparam int SAFE_BLUE_BIT                = 5;
  localparam int DIM_RED_BIT                  = 4;
  localparam int DIM_GREEN_BIT                = 3;
  localparam int DIM_BLUE_BIT                 = 2;
  localparam int DIM_PRIMARY_BIT              = 1;
  localparam int DIM_SECONDARY_BIT            = 0;
  localparam int DIM_FIELD_MSB                = 4;
  localparam int DIM_FIELD_WIDTH              = 5;

  // ----------------------------------------------------------------------
  // Serial interface
  // ----------------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR_DEFAULT     = 7'h2A;  // Arbitrary value
  localparam logic [2:0] BIT_LAST             = 3'h7;
  localparam logic [2:0] BIT_FIRST            = 3'h0;
  localparam int BYTE_MSB                     = 7;
  localparam int ADDR_RW_BIT                  = 0;
  localparam logic [2:0] PIN_SYNC_INIT        = 3'h3;   // pwm low, sda and scl idle high

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RX     = 3'h1,
    ST_RX_ACK = 3'h2,
    ST_TX     = 3'h3,
    ST_TX_ACK = 3'h4
  } serial_state_t;

endpackage

// File: hdl/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int               WIDTH = 3,
  parameter logic [WIDTH-1:0] INIT  = '0
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // ----------------------------------------------------------------------
  // One pair of flops per pin; only the second flop is read outside
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    always_ff @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta_q[i] <= INIT[i];
        q[i]      <= INIT[i];
      end
      else if (ce)
      begin
        meta_q[i] <= d[i];
        q[i]      <= meta_q[i];
      end
    end
  end

endmodule // pin_sync

// File: hdl/lighting_ctrl_regs.sv
// Serial-accessed boost level and external dimming/safety select registers
//
// Summary of operation
// - Boost code is the target output voltage in volts, 8 to 20 V.
// - Boost register resets to 0x08, lowest level, all bits read and write.
// - Bit 7 enables red output flash safety function.
// - Bit 6 enables green output flash safety function.
// - Bit 5 enables blue output flash safety function.
// - Bit 4 lets external PWM pin control red output.
// - Bit 3 lets external PWM pin control green output.
// - Bit 2 lets external PWM pin control blue output.
// - Bit 1 lets external PWM pin dim primary backlight string.
// - Bit 0 lets external PWM pin dim secondary backlight string.
// - External control register fully read-write, resets to zero.
// - External PWM pin acts only while its global pin enable is set.
`timescale 1ns/1ps
module lighting_ctrl_regs #(
  parameter logic [6:0] DEV_ADDR = lighting_regs_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic       pwm_in,
  input  wire logic       pwm_pin_enable,
  output logic            sda_o,
  output logic            sda_oe,
  output logic      [7:0] boost_target_volts,
  output logic            boost_in_range,
  output logic            red_flash_safety_enable,
  output logic            green_flash_safety_enable,
  output logic            blue_flash_safety_enable,
  output logic      [4:0] external_dimming_select,
  output logic            red_led_output_ext_pwm,
  output logic            green_led_output_ext_pwm,
  output logic            blue_led_output_ext_pwm,
  output logic            primary_string_ext_pwm,
  output logic            secondary_string_ext_pwm
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta_q;
  logic rst_n_q;

  // Runs without the clock enable so reset can always release
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ----------------------------------------------------------------------
  // Pin inputs and bus edges
  // ----------------------------------------------------------------------
  logic [2:0] pin_s;
  logic       scl_s;
  logic       sda_s;
  logic       pwm_s;
  logic       scl_prev_q;
  logic       sda_prev_q;

  pin_sync #(
    .WIDTH (3),
    .INIT  (lighting_regs_pkg::PIN_SYNC_INIT)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n_q),
    .ce    (ce),
    .d     ({pwm_in, sda_i, scl_i}),
    .q     (pin_s)
  );

  assign scl_s = pin_s[0];
  assign sda_s = pin_s[1];
  assign pwm_s = pin_s[2];

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end
    else if (ce)
    begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;
  assign start_c  = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_c   = scl_s && scl_prev_q && !sda_prev_q && sda_s;

  // ----------------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------------
  logic [7:0] boost_q;
  logic [7:0] ext_q;
  logic [7:0] ptr_q;
  logic [7:0] shreg_q;
  logic [7:0] rd_data;

  function automatic logic hit(input logic [7:0] ptr, input logic [7:0] offset);
    hit = (ptr == offset);
  endfunction

  always_comb
  begin
    rd_data = lighting_regs_pkg::UNMAPPED_READ;
    if (hit(ptr_q, lighting_regs_pkg::BOOST_LEVEL_OFFSET))
      rd_data = boost_q;
    else if (hit(ptr_q, lighting_regs_pkg::EXT_DIM_SAFE_OFFSET))
      rd_data = ext_q;
  end

  // ----------------------------------------------------------------------
  // Serial slave: 7-bit address, pointer byte, data with auto-increment
  // ----------------------------------------------------------------------
  lighting_regs_pkg::serial_state_t state_q;
  logic [2:0] cnt_q;
  logic [7:0] txsh_q;
  logic       first_q;
  logic       ptr_phase_q;
  logic       rx_full_q;
  logic       tx_done_q;
  logic       rw_q;
  logic       host_ack_q;
  logic       sda_oe_q;
  logic       sda_o_q;
  logic       wr_stb;

  assign wr_stb = scl_fall && rx_full_q && (state_q == lighting_regs_pkg::ST_RX)
                  && !first_q && !ptr_phase_q;

  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state_q     <= lighting_regs_pkg::ST_IDLE;
      cnt_q       <= lighting_regs_pkg::BIT_FIRST;
      shreg_q     <= 8'h00;
      txsh_q      <= 8'h00;
      ptr_q       <= 8'h00;
      first_q     <= 1'b0;
      ptr_phase_q <= 1'b0;
      rx_full_q   <= 1'b0;
      tx_done_q   <= 1'b0;
      rw_q        <= 1'b0;
      host_ack_q  <= 1'b0;
      sda_oe_q    <= 1'b0;
    end
    else if (ce)
    begin
      if (start_c)
      begin
        state_q   <= lighting_regs_pkg::ST_RX;
        first_q   <= 1'b1;
        cnt_q     <= lighting_regs_pkg::BIT_FIRST;
        rx_full_q <= 1'b0;
        tx_done_q <= 1'b0;
        sda_oe_q  <= 1'b0;
      end
      else if (stop_c)
      begin
        state_q  <= lighting_regs_pkg::ST_IDLE;
        sda_oe_q <= 1'b0;
      end
      else
      begin
        unique case (state_q)
          lighting_regs_pkg::ST_IDLE: ;
          lighting_regs_pkg::ST_RX:
          begin
            if (scl_rise)
            begin
              shreg_q   <= {shreg_q[6:0], sda_s};
              cnt_q     <= cnt_q + 3'h1;
              rx_full_q <= (cnt_q == lighting_regs_pkg::BIT_LAST);
            end
            else if (scl_fall && rx_full_q)
            begin
              rx_full_q <= 1'b0;
              if (first_q)
              begin
                if (shreg_q[7:1] == DEV_ADDR)
                begin
                  sda_oe_q    <= 1'b1;
                  rw_q        <= shreg_q[lighting_regs_pkg::ADDR_RW_BIT];
                  ptr_phase_q <= !shreg_q[lighting_regs_pkg::ADDR_RW_BIT];
                  first_q     <= 1'b0;
                  state_q     <= lighting_regs_pkg::ST_RX_ACK;
                end
                else
                  state_q <= lighting_regs_pkg::ST_IDLE;
              end
              else
              begin
                sda_oe_q <= 1'b1;
                state_q  <= lighting_regs_pkg::ST_RX_ACK;
                if (ptr_phase_q)
                begin
                  ptr_q       <= shreg_q;
                  ptr_phase_q <= 1'b0;
                end
                else
                  ptr_q <= ptr_q + 8'h01;
              end
            end
          end
          lighting_regs_pkg::ST_RX_ACK:
          begin
            if (scl_fall)
            begin
              cnt_q <= lighting_regs_pkg::BIT_FIRST;
              if (rw_q)
              begin
                txsh_q   <= rd_data;
                sda_oe_q <= !rd_data[lighting_regs_pkg::BYTE_MSB];
                state_q  <= lighting_regs_pkg::ST_TX;
              end
              else
              begin
                sda_oe_q <= 1'b0;
                state_q  <= lighting_regs_pkg::ST_RX;
              end
            end
          end
          lighting_regs_pkg::ST_TX:
          begin
            if (scl_rise)
            begin
              cnt_q     <= cnt_q + 3'h1;
              tx_done_q <= (cnt_q == lighting_regs_pkg::BIT_LAST);
            end
            else if (scl_fall)
            begin
              if (tx_done_q)
              begin
                sda_oe_q  <= 1'b0;
                tx_done_q <= 1'b0;
                state_q   <= lighting_regs_pkg::ST_TX_ACK;
              end
              else
              begin
                txsh_q   <= {txsh_q[6:0], 1'b0};
                sda_oe_q <= !txsh_q[6];
              end
            end
          end
          lighting_regs_pkg::ST_TX_ACK:
          begin
            if (scl_rise)
            begin
              host_ack_q <= !sda_s;
              if (!sda_s)
                ptr_q <= ptr_q + 8'h01;
            end
            else if (scl_fall)
            begin
              if (host_ack_q)
              begin
                txsh_q   <= rd_data;
                sda_oe_q <= !rd_data[lighting_regs_pkg::BYTE_MSB];
                cnt_q    <= lighting_regs_pkg::BIT_FIRST;
                state_q  <= lighting_regs_pkg::ST_TX;
              end
              else
                state_q <= lighting_regs_pkg::ST_IDLE;
            end
          end
          default: state_q <= lighting_regs_pkg::ST_IDLE;
        endcase
      end
    end
  end

  // Open drain: the data line is only ever pulled low
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
      sda_o_q <= 1'b0;
    else if (ce)
      sda_o_q <= 1'b0;
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      boost_q <= lighting_regs_pkg::BOOST_LEVEL_RESET;
      ext_q   <= lighting_regs_pkg::EXT_DIM_SAFE_RESET;
    end
    else if (ce && wr_stb)
    begin
      if (hit(ptr_q, lighting_regs_pkg::BOOST_LEVEL_OFFSET))
        boost_q <= shreg_q;
      if (hit(ptr_q, lighting_regs_pkg::EXT_DIM_SAFE_OFFSET))
        ext_q <= shreg_q;
    end
  end

  // ----------------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------------
  logic [7:0] volts_q;
  logic       in_range_q;
  logic [2:0] safe_q;
  logic [4:0] sel_q;
  logic [4:0] dim_q;

  // Codes outside 8..20 pass through but are flagged; the host must avoid them
  always_ff @(posedge clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      volts_q    <= lighting_regs_pkg::BOOST_LEVEL_RESET;
      in_range_q <= 1'b1;
      safe_q     <= 3'h0;
      sel_q      <= 5'h00;
      dim_q      <= 5'h00;
    end
    else if (ce)
    begin
      volts_q    <= boost_q;
      in_range_q <= (boost_q >= lighting_regs_pkg::BOOST_CODE_MIN)
                    && (boost_q <= lighting_regs_pkg::BOOST_CODE_MAX);
      safe_q     <= {ext_q[lighting_regs_pkg::SAFE_RED_BIT],
                     ext_q[lighting_regs_pkg::SAFE_GREEN_BIT],
                     ext_q[lighting_regs_pkg::SAFE_BLUE_BIT]};
      sel_q      <= ext_q[lighting_regs_pkg::DIM_FIELD_MSB:0];
      // Pin enable gates every selection at once
      dim_q      <= ext_q[lighting_regs_pkg::DIM_FIELD_MSB:0]
                    & {lighting_regs_pkg::DIM_FIELD_WIDTH{pwm_pin_enable && pwm_s}};
    end
  end

  assign sda_o                     = sda_o_q;
  assign sda_oe                    = sda_oe_q;
  assign boost_target_volts        = volts_q;
  assign boost_in_range            = in_range_q;
  assign red_flash_safety_enable   = safe_q[2];
  assign green_flash_safety_enable = safe_q[1];
  assign blue_flash_safety_enable  = safe_q[0];
  assign external_dimming_select   = sel_q;
  assign red_led_output_ext_pwm    = dim_q[lighting_regs_pkg::DIM_RED_BIT];
  assign green_led_output_ext_pwm  = dim_q[lighting_regs_pkg::DIM_GREEN_BIT];
  assign blue_led_output_ext_pwm   = dim_q[lighting_regs_pkg::DIM_BLUE_BIT];
  assign primary_string_ext_pwm    = dim_q[lighting_regs_pkg::DIM_PRIMARY_BIT];
  assign secondary_string_ext_pwm  = dim_q[lighting_regs_pkg::DIM_SECONDARY_BIT];

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic pwm_go;
  assign pwm_go = ce && pwm_pin_enable && pwm_s;

  sequence addr_byte_seen;
    ce && scl_fall && rx_full_q && first_q && (state_q == lighting_regs_pkg::ST_RX)
      && (shreg_q[7:1] == DEV_ADDR);
  endsequence

  sequence ack_driven;
    sda_oe_q && (state_q == lighting_regs_pkg::ST_RX_ACK);
  endsequence

  reset_values_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    $past(!rst_n_q) |-> (boost_q == lighting_regs_pkg::BOOST_LEVEL_RESET)
                        && (ext_q == lighting_regs_pkg::EXT_DIM_SAFE_RESET))
    else $error("registers not at reset values after release");

  boost_write_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && wr_stb && hit(ptr_q, lighting_regs_pkg::BOOST_LEVEL_OFFSET)
      |=> boost_q == $past(shreg_q))
    else $error("boost level write not stored");

  boost_volts_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && (boost_q >= lighting_regs_pkg::BOOST_CODE_MIN)
      && (boost_q <= lighting_regs_pkg::BOOST_CODE_MAX)
      |=> (boost_target_volts == $past(boost_q)) && boost_in_range)
    else $error("boost voltage not equal to code");

  safety_red_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && wr_stb && hit(ptr_q, lighting_regs_pkg::EXT_DIM_SAFE_OFFSET)
      |=> ce ##1 red_flash_safety_enable
                 == $past(shreg_q[lighting_regs_pkg::SAFE_RED_BIT], 2))
    else $error("red safety enable wrong");

  safety_green_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && $past(ce)
      |-> green_flash_safety_enable == $past(ext_q[lighting_regs_pkg::SAFE_GREEN_BIT]))
    else $error("green safety enable wrong");

  safety_blue_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && $past(ce)
      |-> blue_flash_safety_enable == $past(ext_q[lighting_regs_pkg::SAFE_BLUE_BIT]))
    else $error("blue safety enable wrong");

  dim_red_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    pwm_go && ext_q[lighting_regs_pkg::DIM_RED_BIT] |=> red_led_output_ext_pwm)
    else $error("red external pwm not passed");

  dim_green_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && !ext_q[lighting_regs_pkg::DIM_GREEN_BIT] |=> !green_led_output_ext_pwm)
    else $error("green external pwm leaks when deselected");

  dim_blue_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    pwm_go && ext_q[lighting_regs_pkg::DIM_BLUE_BIT] |=> blue_led_output_ext_pwm)
    else $error("blue external pwm not passed");

  dim_primary_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    pwm_go && ext_q[lighting_regs_pkg::DIM_PRIMARY_BIT] |=> primary_string_ext_pwm)
    else $error("primary string external pwm not passed");

  dim_secondary_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    pwm_go && ext_q[lighting_regs_pkg::DIM_SECONDARY_BIT] |=> secondary_string_ext_pwm)
    else $error("secondary string external pwm not passed");

  pin_gate_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    ce && !pwm_pin_enable |=> (dim_q == 5'h00))
    else $error("external pwm active with pin disabled");

  addr_ack_a: assert property (@(posedge clk) disable iff (!rst_n_q)
    addr_byte_seen |=> ack_driven)
    else $error("address not acknowledged");

endmodule // lighting_ctrl_regs

// File: dv/i2c_host_model.sv
// Host processor model driving the two-wire register bus
`timescale 1ns/1ps
module i2c_host_model (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // ----------------------------------------------------------------------
  // Bit level, every phase six clocks to clear the pin synchronisers
  // ----------------------------------------------------------------------
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic put_bit(input logic b);
    sda_low <= ~b;
    tick(6);
    scl <= 1'b1;
    tick(6);
    scl <= 1'b0;
    tick(6);
  endtask

  // Sampled mid-high, after the device has had time to settle its bit
  task automatic get_bit(output logic b);
    sda_low <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(3);
    b = sda;
    tick(3);
    scl <= 1'b0;
    tick(6);
  endtask

  task automatic start_cond();
    sda_low <= 1'b0;
    tick(6);
    scl <= 1'b1;
    tick(6);
    sda_low <= 1'b1;
    tick(6);
    scl <= 1'b0;
    tick(6);
  endtask

  task automatic stop_cond();
    sda_low <= 1'b1;
    tick(6);
    scl <= 1'b1;
    tick(6);
    sda_low <= 1'b0;
    tick(6);
  endtask

  // Byte goes MSB first; returns the acknowledge level, low when taken
  task automatic send(input logic [7:0] v, output logic nak);
    for (int i = 7; i >= 0; i--)
      put_bit(v[i]);
    get_bit(nak);
  endtask

  // ----------------------------------------------------------------------
  // Register transfers
  // ----------------------------------------------------------------------
  task automatic write_reg(input logic [6:0] dev, input logic [7:0] ptr,
                           input logic [7:0] data, output logic nak);
    logic n0;
    logic n1;
    logic n2;
    start_cond();
    send({dev, 1'b0}, n0);
    send(ptr, n1);
    send(data, n2);
    stop_cond();
    nak = n0 | n1 | n2;
  endtask

  // Pointer set, repeated start, one byte read and closed with a NACK
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr,
                          output logic [7:0] data, output logic nak);
    logic n0;
    logic n1;
    logic n2;
    start_cond();
    send({dev, 1'b0}, n0);
    send(ptr, n1);
    start_cond();
    send({dev, 1'b1}, n2);
    for (int i = 7; i >= 0; i--)
      get_bit(data[i]);
    put_bit(1'b1);
    stop_cond();
    nak = n0 | n1 | n2;
  endtask
endmodule // i2c_host_model

// File: dv/testbench.sv
// Self-checking bench for the boost level and external control registers
`timescale 1ns/1ps
module testbench;
  logic       clk;
  logic       resetn;
  logic       ce;
  logic       pwm_in;
  logic       pwm_pin_enable;
  logic       scl;
  logic       sda_low;
  logic       sda_o;
  logic       sda_oe;
  wire        sda;
  logic [7:0] volts;
  logic       in_range;
  logic       saf_r;
  logic       saf_g;
  logic       saf_b;
  logic [4:0] dim_sel;
  logic [4:0] ext;
  logic [7:0] rd;
  logic       nak;
  int         n_fail;
  int         check_count;
  localparam logic [6:0] DEV = lighting_regs_pkg::DEV_ADDR_DEFAULT;
  logic [7:0] boost_codes [3] = '{8'h08, 8'h0C, 8'h14};

  // Open-drain bus with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & ~sda_low;

  lighting_ctrl_regs dut (
    .clk                       (clk),
    .resetn                    (resetn),
    .ce                        (ce),
    .scl_i                     (scl),
    .sda_i                     (sda),
    .pwm_in                    (pwm_in),
    .pwm_pin_enable            (pwm_pin_enable),
    .sda_o                     (sda_o),
    .sda_oe                    (sda_oe),
    .boost_target_volts        (volts),
    .boost_in_range            (in_range),
    .red_flash_safety_enable   (saf_r),
    .green_flash_safety_enable (saf_g),
    .blue_flash_safety_enable  (saf_b),
    .external_dimming_select   (dim_sel),
    .red_led_output_ext_pwm    (ext[4]),
    .green_led_output_ext_pwm  (ext[3]),
    .blue_led_output_ext_pwm   (ext[2]),
    .primary_string_ext_pwm    (ext[1]),
    .secondary_string_ext_pwm  (ext[0])
  );

  i2c_host_model host (
    .clk     (clk),
    .sda     (sda),
    .scl     (scl),
    .sda_low (sda_low)
  );

  // ----------------------------------------------------------------------
  // Clock, compare and closing
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [7:0] ctl_view();
    return {saf_r, saf_g, saf_b, dim_sel};
  endfunction

  // Hang guard: a run beyond this bound counts as a mismatch
  initial
  begin
    repeat (100000) @(posedge clk);
    n_fail++;
    end_sim();
  end

  task automatic do_reset();
    resetn <= 1'b0;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    check_count = 0;
    resetn = 1'b0;
    ce = 1'b1;
    pwm_in = 1'b0;
    pwm_pin_enable = 1'b0;
    do_reset();
    chk(volts, 8'h08);
    chk(ctl_view(), 8'h00);
    host.read_reg(DEV, 8'h0D, rd, nak);
    chk(rd, 8'h08);
    host.read_reg(DEV, 8'h2B, rd, nak);
    chk(rd, 8'h00);
    // Range ends and one mid code, all within what the host may write
    foreach (boost_codes[i])
    begin
      rd = boost_codes[i];
      host.write_reg(DEV, 8'h0D, rd, nak);
      chk({7'h00, nak}, 8'h00);
      chk(volts, rd);
      chk({7'h00, in_range}, 8'h01);
    end
    // All bits but bit 3 set and read back; the code is outside the volt range
    host.write_reg(DEV, 8'h0D, 8'hF7, nak);
    host.read_reg(DEV, 8'h0D, rd, nak);
    chk(rd, 8'hF7);
    chk({7'h00, in_range}, 8'h00);
    // Walking one over the external control register
    for (int i = 0; i < 8; i++)
    begin
      host.write_reg(DEV, 8'h2B, 8'h01 << i, nak);
      host.read_reg(DEV, 8'h2B, rd, nak);
      chk(rd, 8'h01 << i);
      chk(ctl_view(), 8'h01 << i);
    end
    // External PWM passes only with the global pin enable set
    host.write_reg(DEV, 8'h2B, 8'h1F, nak);
    pwm_in <= 1'b1;
    repeat (6) @(posedge clk);
    chk({3'h0, ext}, 8'h00);
    pwm_pin_enable <= 1'b1;
    repeat (6) @(posedge clk);
    chk({3'h0, ext}, 8'h1F);
    pwm_in <= 1'b0;
    repeat (6) @(posedge clk);
    chk({3'h0, ext}, 8'h00);
    host.write_reg(DEV, 8'h2B, 8'hEA, nak);
    pwm_in <= 1'b1;
    repeat (6) @(posedge clk);
    chk({3'h0, ext}, 8'h0A);
    // Clock enable low freezes the outputs even while the pin moves
    ce <= 1'b0;
    pwm_in <= 1'b0;
    repeat (6) @(posedge clk);
    chk({3'h0, ext}, 8'h0A);
    ce <= 1'b1;
    repeat (6) @(posedge clk);
    chk({3'h0, ext}, 8'h00);
    // Unmapped pointer reads zero; a foreign address is not acknowledged
    host.read_reg(DEV, 8'h40, rd, nak);
    chk(rd, 8'h00);
    host.write_reg(DEV ^ 7'h01, 8'h0D, 8'h10, nak);
    chk({7'h00, nak}, 8'h01);
    chk(volts, 8'hF7);
    // Second reset in mid-run restores both registers
    do_reset();
    chk(volts, 8'h08);
    chk(ctl_view(), 8'h00);
    chk({3'h0, ext}, 8'h00);
    end_sim();
  end
endmodule // testbench
